// file: tag_memory_access_control.v
// tag memory access control: pages, locks, auth and config
`timescale 1ns/1ps
`include "tag_access_defines.vh"
module tag_memory_access_control (
  input wire clk,
  input wire srst,
  input wire [7:0] radio_page,
  input wire [31:0] radio_wdata,
  input wire radio_wr,
  input wire radio_rd,
  output reg [31:0] radio_rdata,
  output reg radio_ack,
  output reg radio_nak,
  input wire [7:0] host_page,
  input wire [31:0] host_wdata,
  input wire host_wr,
  input wire host_rd,
  output reg [31:0] host_rdata,
  output reg host_ack,
  output reg host_nak,
  input wire cmd_valid,
  input wire [7:0] cmd_code,
  output reg cascade_one_select,
  output reg cascade_two_select,
  output reg [31:0] cascade_data,
  input wire password_check,
  input wire [31:0] password_try,
  output reg auth_ok,
  output reg auth_fail,
  output reg [15:0] password_ack_value,
  output reg authenticated,
  output reg auth_locked_out,
  input wire field_present,
  input wire sof_seen,
  input wire selected,
  input wire halted,
  input wire buf_ready_for_host,
  input wire buf_read_by_reader,
  input wire buf_last_read_by_host,
  output wire field_flag_pin_o,
  output reg field_flag_pin_oe,
  output reg silence_and_soft_reset_enable,
  output reg passthru_enable,
  output reg mirror_enable,
  output reg transfer_dir,
  output reg passthru_password_protect,
  output reg [1:0] host_port_protect,
  output reg [7:0] final_message_block,
  output reg [7:0] mirror_base_block,
  output reg [15:0] watchdog_timeout
);

  // ========================================================
  // storage
  reg [7:0] static_lock_low_q;
  reg [7:0] static_lock_high_q;
  reg [31:0] capability_bytes_q;
  reg [31:0] user_mem_q [`PAGE_DATA_FIRST:`PAGE_DATA_LAST];
  reg [7:0] dynamic_lock_first_q;
  reg [7:0] dynamic_lock_second_q;
  reg [7:0] dynamic_lock_freeze_q;
  reg [7:0] protected_start_page_q;
  reg [7:0] access_condition_q;
  reg [31:0] password_value_q;
  reg [15:0] password_ack_q;
  reg [7:0] host_protection_bits_q;
  reg [7:0] session_control_q;
  reg [7:0] final_message_block_q;
  reg [7:0] mirror_base_block_q;
  reg [7:0] watchdog_timeout_low_q;
  reg [7:0] watchdog_timeout_high_q;
  reg [7:0] host_clock_stretch_q;
  reg [7:0] configuration_lock_q;
  reg [7:0] fail_count_q;
  integer i;

  // serial identifier is wired, so no write can reach it
  wire [55:0] tag_serial_id = {`SERIAL_NUMBER, `MAKER_CODE};

  // ========================================================
  // lock decode
  // which static lock bits the radio may still set
  wire [7:0] low_allow = {{4{~static_lock_low_q[`FREEZE_MID]}},
                          ~static_lock_low_q[`FREEZE_OTP], 3'b111};
  wire [7:0] high_allow = {{6{~static_lock_low_q[`FREEZE_TOP]}},
                           {2{~static_lock_low_q[`FREEZE_MID]}}};
  wire [15:0] dyn_locks = {dynamic_lock_second_q, dynamic_lock_first_q};
  wire [15:0] dyn_allow;
  genvar k;
  // each freeze bit governs a pair of dynamic lock bits
  generate
    for (k = 0; k < 7; k = k + 1) begin : g_freeze
      assign dyn_allow[2*k+1:2*k] = {2{~dynamic_lock_freeze_q[k]}};
    end
  endgenerate
  assign dyn_allow[15:14] = 2'b00; // reserved bits never set

  // page read-only from the lock bits; covers pages 3..225
  reg page_locked;
  reg [7:0] dyn_idx;
  always @* begin
    dyn_idx = radio_page - `PAGE_DYN_FIRST;
    page_locked = 1'b0;
    if (radio_page == `PAGE_CAP) begin
      page_locked = static_lock_low_q[`OTP_LOCK_BIT];
    end else if (radio_page > `PAGE_CAP && radio_page < 8'h08) begin
      page_locked = static_lock_low_q[radio_page[2:0]];
    end else if (radio_page > 8'h07 &&
                 radio_page <= `PAGE_STATIC_LAST) begin
      page_locked = static_lock_high_q[radio_page[2:0]];
    end else if (radio_page >= `PAGE_DYN_FIRST &&
                 radio_page <= `PAGE_DATA_LAST) begin
      page_locked = dyn_locks[dyn_idx[7:4]];
    end
  end

  // ========================================================
  // protection decode
  // pointer above the highest user page disables it
  wire prot_on = protected_start_page_q <= `PAGE_HIGHEST_USER;
  wire radio_prot = prot_on && radio_page >= protected_start_page_q;
  wire host_prot = prot_on && host_page >= protected_start_page_q;
  wire radio_cfg = radio_page >= `PAGE_PROT_START &&
                   radio_page <= `PAGE_SESSION_B;
  wire host_cfg = host_page >= `PAGE_PROT_START &&
                  host_page <= `PAGE_SESSION_B;
  // configuration pages from the access page (E4) on stay reachable for the host
  wire host_free = host_page >= `PAGE_ACCESS &&
                   host_page <= `PAGE_SESSION_B;
  wire radio_valid = radio_page <= `PAGE_SESSION_B;
  wire host_valid = host_page <= `PAGE_SESSION_B;

  // radio reads need auth only with read protect set
  wire radio_rd_ok = radio_valid && !(radio_prot && !authenticated &&
                     access_condition_q[`ACC_READ_PROT]);
  // writes at or above the pointer need auth; locks make pages read-only
  wire radio_wr_ok = radio_valid && radio_page > `PAGE_SERIAL_HI &&
                     !page_locked &&
                     !(radio_prot && !authenticated) &&
                     !(radio_cfg &&
                       configuration_lock_q[`LOCK_RADIO_CFG]);
  // host protect: 01 blocks writes, 1x blocks reads too
  wire host_rd_ok = host_valid &&
                    !(host_prot && !host_free && host_port_protect[1]);
  wire host_wr_ok = host_valid && host_page > `PAGE_SERIAL_HI &&
                    !(host_prot && !host_free &&
                      host_port_protect != 2'b00) &&
                    !(host_cfg &&
                      configuration_lock_q[`LOCK_HOST_CFG]) &&
                    !radio_wr; // same-cycle radio write takes the port

  // ========================================================
  // read mux shared by both ports
  function [31:0] page_data;
    input [7:0] p;
    begin
      page_data = `ZERO32;
      if (p == `PAGE_SERIAL_LO) begin
        page_data = tag_serial_id[55:24];
      end else if (p == `PAGE_SERIAL_HI) begin
        page_data = {tag_serial_id[23:0], `PAGE1_BYTE3};
      end else if (p == `PAGE_STATIC_LOCK) begin
        page_data = {`ATQA_BYTES, static_lock_low_q, static_lock_high_q};
      end else if (p == `PAGE_CAP) begin
        page_data = capability_bytes_q;
      end else if (p >= `PAGE_DATA_FIRST && p <= `PAGE_DATA_LAST) begin
        page_data = user_mem_q[p];
      end else if (p == `PAGE_DYN_LOCK) begin
        page_data = {dynamic_lock_first_q, dynamic_lock_second_q,
                     dynamic_lock_freeze_q, `ZERO8};
      end else if (p == `PAGE_PROT_START) begin
        page_data = {`ZERO16, `ZERO8, protected_start_page_q};
      end else if (p == `PAGE_ACCESS) begin
        page_data = {access_condition_q, `ZERO16, `ZERO8};
      end else if (p == `PAGE_HOST_PROT) begin
        page_data = {host_protection_bits_q, `ZERO16, `ZERO8};
      end else if (p == `PAGE_SESSION_A) begin
        page_data = {session_control_q, final_message_block_q,
                     mirror_base_block_q, watchdog_timeout_low_q};
      end else if (p == `PAGE_SESSION_B) begin
        page_data = {watchdog_timeout_high_q, host_clock_stretch_q,
                     configuration_lock_q, `ZERO8};
      end
      // password pages fall through and read as zeros
    end
  endfunction

  // ========================================================
  // page write, shared; from_host picks clear-capable lock writes
  task write_page;
    input [7:0] p;
    input [31:0] d;
    input from_host;
    begin
      if (p == `PAGE_STATIC_LOCK) begin
        // bytes 0 and 1 of this page are untouched
        if (from_host) begin
          static_lock_low_q <= d[15:8];
          static_lock_high_q <= d[7:0];
        end else begin
          static_lock_low_q <= static_lock_low_q |
                               (d[15:8] & low_allow);
          static_lock_high_q <= static_lock_high_q |
                                (d[7:0] & high_allow);
        end
      end else if (p == `PAGE_CAP) begin
        if (from_host) begin
          capability_bytes_q <= d;
        end else begin
          capability_bytes_q <= capability_bytes_q | d;
        end
      end else if (p >= `PAGE_DATA_FIRST && p <= `PAGE_DATA_LAST) begin
        user_mem_q[p] <= d;
      end else if (p == `PAGE_DYN_LOCK) begin
        if (from_host) begin
          dynamic_lock_first_q <= d[31:24];
          dynamic_lock_second_q <= d[23:16] & `DYN_SECOND_MASK;
          dynamic_lock_freeze_q <= d[15:8] & `DYN_FREEZE_MASK;
        end else begin
          dynamic_lock_first_q <= dynamic_lock_first_q |
                                  (d[31:24] & dyn_allow[7:0]);
          dynamic_lock_second_q <= dynamic_lock_second_q |
                                   (d[23:16] & dyn_allow[15:8]);
          dynamic_lock_freeze_q <= dynamic_lock_freeze_q |
                                   (d[15:8] & `DYN_FREEZE_MASK);
        end
      end else if (p == `PAGE_PROT_START) begin
        protected_start_page_q <= d[7:0];
      end else if (p == `PAGE_ACCESS) begin
        access_condition_q <= d[31:24] & `ACCESS_MASK;
      end else if (p == `PAGE_PASSWORD) begin
        password_value_q <= d;
      end else if (p == `PAGE_PASSWORD_ACK) begin
        password_ack_q <= d[31:16];
      end else if (p == `PAGE_HOST_PROT) begin
        host_protection_bits_q <= d[31:24] & `HOST_PROT_MASK;
      end else if (p == `PAGE_SESSION_A) begin
        session_control_q <= d[31:24];
        final_message_block_q <= d[23:16];
        mirror_base_block_q <= d[15:8];
        watchdog_timeout_low_q <= d[7:0];
      end else if (p == `PAGE_SESSION_B) begin
        watchdog_timeout_high_q <= d[31:24];
        host_clock_stretch_q <= d[23:16] & `CLK_STRETCH_MASK;
        // lock bits only ever accumulate
        configuration_lock_q <= configuration_lock_q |
                                (d[15:8] & `CFG_LOCK_MASK);
      end
    end
  endtask

  // ========================================================
  // register file and port answers
  always @(posedge clk) begin
    if (srst) begin
      static_lock_low_q <= `ZERO8;
      static_lock_high_q <= `ZERO8;
      capability_bytes_q <= `CAP_RESET;
      for (i = `PAGE_DATA_FIRST; i <= `PAGE_DATA_LAST; i = i + 1) begin
        user_mem_q[i] <= `ZERO32;
      end
      user_mem_q[`PAGE_DATA_FIRST] <= `DATA4_RESET;
      dynamic_lock_first_q <= `ZERO8;
      dynamic_lock_second_q <= `ZERO8;
      dynamic_lock_freeze_q <= `ZERO8;
      protected_start_page_q <= `PROT_START_RESET;
      access_condition_q <= `ZERO8;
      password_value_q <= `PASSWORD_RESET;
      password_ack_q <= `ACK_VALUE_RESET;
      host_protection_bits_q <= `ZERO8;
      session_control_q <= `SESSION_CTRL_RESET;
      final_message_block_q <= `FINAL_MSG_RESET;
      mirror_base_block_q <= `MIRROR_BASE_RESET;
      watchdog_timeout_low_q <= `WDT_LO_RESET;
      watchdog_timeout_high_q <= `WDT_HI_RESET;
      host_clock_stretch_q <= `CLK_STRETCH_RESET;
      configuration_lock_q <= `ZERO8;
      radio_rdata <= `ZERO32;
      radio_ack <= 1'b0;
      radio_nak <= 1'b0;
      host_rdata <= `ZERO32;
      host_ack <= 1'b0;
      host_nak <= 1'b0;
    end else begin
      radio_ack <= (radio_wr && radio_wr_ok) ||
                   (radio_rd && !radio_wr && radio_rd_ok);
      radio_nak <= (radio_wr && !radio_wr_ok) ||
                   (radio_rd && !radio_wr && !radio_rd_ok);
      host_ack <= (host_wr && host_wr_ok) ||
                  (host_rd && !host_wr && host_rd_ok);
      host_nak <= (host_wr && !host_wr_ok) ||
                  (host_rd && !host_wr && !host_rd_ok);
      if (radio_rd && !radio_wr) begin
        radio_rdata <= radio_rd_ok ? page_data(radio_page) : `ZERO32;
      end
      if (host_rd && !host_wr) begin
        host_rdata <= host_rd_ok ? page_data(host_page) : `ZERO32;
      end
      if (host_wr && host_wr_ok) begin
        write_page(host_page, host_wdata, 1'b1);
      end
      if (radio_wr && radio_wr_ok) begin
        write_page(radio_page, radio_wdata, 1'b0);
      end
    end
  end

  // ========================================================
  // configuration outputs; watchdog value moves on high-byte write
  always @(posedge clk) begin
    if (srst) begin
      watchdog_timeout <= {`WDT_HI_RESET, `WDT_LO_RESET};
    end else if ((radio_wr && radio_wr_ok &&
                  radio_page == `PAGE_SESSION_B) ||
                 (host_wr && host_wr_ok &&
                  host_page == `PAGE_SESSION_B)) begin
      watchdog_timeout <= {radio_wr ? radio_wdata[31:24] :
                           host_wdata[31:24],
                           watchdog_timeout_low_q};
    end
  end

  always @* begin
    silence_and_soft_reset_enable = session_control_q[`SC_SILENCE];
    passthru_enable = session_control_q[`SC_PASSTHRU];
    mirror_enable = session_control_q[`SC_MIRROR];
    transfer_dir = session_control_q[`SC_DIR];
    passthru_password_protect = host_protection_bits_q[`HP_PASSTHRU];
    host_port_protect = host_protection_bits_q[1:0];
    final_message_block = final_message_block_q;
    mirror_base_block = mirror_base_block_q;
  end

  // ========================================================
  // cascade select decode
  always @(posedge clk) begin
    if (srst) begin
      cascade_one_select <= 1'b0;
      cascade_two_select <= 1'b0;
      cascade_data <= `ZERO32;
    end else begin
      cascade_one_select <= cmd_valid &&
                            cmd_code == `CMD_CASCADE_ONE;
      cascade_two_select <= cmd_valid &&
                            cmd_code == `CMD_CASCADE_TWO;
      if (cmd_valid && cmd_code == `CMD_CASCADE_ONE) begin
        cascade_data <= {`CASCADE_TAG, tag_serial_id[55:32]};
      end else if (cmd_valid && cmd_code == `CMD_CASCADE_TWO) begin
        cascade_data <= tag_serial_id[31:0];
      end
    end
  end

  // ========================================================
  // password check and failure limiter
  // limit 2^n compared in 9 bits so n=7 cannot overflow
  wire [8:0] fail_limit = 9'h001 << access_condition_q[2:0];
  wire limit_on = access_condition_q[2:0] != 3'b000;
  wire pwd_match = password_try == password_value_q;
  always @(posedge clk) begin
    if (srst) begin
      fail_count_q <= `ZERO8;
      auth_ok <= 1'b0;
      auth_fail <= 1'b0;
      authenticated <= 1'b0;
      auth_locked_out <= 1'b0;
      password_ack_value <= `ZERO16;
    end else begin
      auth_ok <= password_check && pwd_match && !auth_locked_out;
      auth_fail <= password_check && !(pwd_match && !auth_locked_out);
      if (!field_present) begin
        authenticated <= 1'b0; // auth lives for one field session
      end else if (password_check && pwd_match && !auth_locked_out) begin
        authenticated <= 1'b1;
      end
      if (password_check && pwd_match && !auth_locked_out) begin
        password_ack_value <= password_ack_q;
        fail_count_q <= `ZERO8;
      end else if (password_check && limit_on &&
                   fail_count_q != `FAIL_MAX) begin
        fail_count_q <= fail_count_q + `FAIL_ONE;
      end
      // lockout is permanent once the count passes the limit
      if (limit_on && {1'b0, fail_count_q} > fail_limit) begin
        auth_locked_out <= 1'b1;
      end
    end
  end

  // ========================================================
  // field flag pin: open drain, oe high while pulling low
  assign field_flag_pin_o = 1'b0;
  wire [1:0] ff_on = session_control_q[3:2];
  wire [1:0] ff_off = session_control_q[5:4];
  // reader read of the last page of the final message block
  wire last_msg_read = radio_rd && !radio_wr && radio_rd_ok &&
                       {2'b00, radio_page} ==
                       {final_message_block_q, 2'b11};
  reg ff_set;
  reg ff_clr;
  always @* begin
    case (ff_on)
      `FF_FIELD: ff_set = field_present;
      `FF_SOF: ff_set = sof_seen;
      `FF_SELECT: ff_set = selected;
      `FF_BUFFER: ff_set = transfer_dir ? buf_ready_for_host :
                           buf_read_by_reader;
      default: ff_set = 1'b0;
    endcase
    case (ff_off)
      `REL_HALT: ff_clr = halted;
      `REL_LAST: ff_clr = last_msg_read;
      `REL_BUFFER: ff_clr = (ff_on == `FF_BUFFER) &&
                            buf_last_read_by_host;
      default: ff_clr = 1'b0;
    endcase
  end

  // field loss always releases; otherwise an assert event wins
  always @(posedge clk) begin
    if (srst) begin
      field_flag_pin_oe <= 1'b0;
    end else if (!field_present) begin
      field_flag_pin_oe <= 1'b0;
    end else if (ff_set) begin
      field_flag_pin_oe <= 1'b1;
    end else if (ff_clr) begin
      field_flag_pin_oe <= 1'b0;
    end
  end

endmodule

// file: tag_access_defines.vh
// constants of the tag memory access-control block
// Summary of operation
// - fixed seven-byte serial, never writable
// - capability page resets to formatted-data values
// - decode both cascade-level select command codes
// - static lock bits make pages 3-15 read-only
// - static freeze bits inhibit their lock bits
// - lock bytes set-only from radio, host clears
// - dynamic lock bytes cover pages 16-225
// - dynamic freeze bits; reserved bits read zero
// - radio write to page 3 ORs data
// - user pages 4-225; page 4 empty message
// - pages at or above pointer need password
// - read-protect bit extends auth to reads
// - limited failed checks lock out authentication
// - password and acknowledge read back as zeros
// - host protect field and pass-through protect bit
// - session control enables and direction bit
// - field flag assert condition select
// - field flag release condition select
// - final message and mirror block pointers
// - sixteen-bit watchdog timeout from two bytes
// - sticky per-interface configuration locks
`ifndef TAG_ACCESS_DEFINES_VH
`define TAG_ACCESS_DEFINES_VH
// ==========================================================
// page map
`define PAGE_SERIAL_LO 8'h00
`define PAGE_SERIAL_HI 8'h01
`define PAGE_STATIC_LOCK 8'h02
`define PAGE_CAP 8'h03
`define PAGE_DATA_FIRST 8'h04
`define PAGE_STATIC_LAST 8'h0F
`define PAGE_DYN_FIRST 8'h10
`define PAGE_DATA_LAST 8'hE1
`define PAGE_DYN_LOCK 8'hE2
`define PAGE_PROT_START 8'hE3
`define PAGE_ACCESS 8'hE4
`define PAGE_PASSWORD 8'hE5
`define PAGE_PASSWORD_ACK 8'hE6
`define PAGE_HOST_PROT 8'hE7
`define PAGE_SESSION_A 8'hE8
`define PAGE_SESSION_B 8'hE9
`define PAGE_HIGHEST_USER 8'hEB
// ==========================================================
// reset values
`define CAP_RESET 32'hE110_6D00
`define DATA4_RESET 32'h0300_FE00
`define PROT_START_RESET 8'hFF
`define PASSWORD_RESET 32'hFFFF_FFFF
`define ACK_VALUE_RESET 16'h0000
`define SESSION_CTRL_RESET 8'h01
`define FINAL_MSG_RESET 8'h00
`define MIRROR_BASE_RESET 8'hF8
`define WDT_LO_RESET 8'h48
`define WDT_HI_RESET 8'h08
`define CLK_STRETCH_RESET 8'h01
// ==========================================================
// writable-bit masks
`define ACCESS_MASK 8'hA7
`define HOST_PROT_MASK 8'h0F
`define CLK_STRETCH_MASK 8'h01
`define CFG_LOCK_MASK 8'h03
`define DYN_SECOND_MASK 8'h3F
`define DYN_FREEZE_MASK 8'h7F
// ==========================================================
// field positions
`define ACC_READ_PROT 7
`define SC_SILENCE 7
`define SC_PASSTHRU 6
`define SC_MIRROR 1
`define SC_DIR 0
`define HP_PASSTHRU 2
`define LOCK_HOST_CFG 1
`define LOCK_RADIO_CFG 0
`define OTP_LOCK_BIT 3
`define FREEZE_OTP 0
`define FREEZE_MID 1
`define FREEZE_TOP 2
// ==========================================================
// command codes and field flag selections
`define CMD_CASCADE_ONE 8'h93
`define CMD_CASCADE_TWO 8'h95
`define CASCADE_TAG 8'h88
`define FF_FIELD 2'b00
`define FF_SOF 2'b01
`define FF_SELECT 2'b10
`define FF_BUFFER 2'b11
`define REL_HALT 2'b01
`define REL_LAST 2'b10
`define REL_BUFFER 2'b11
// ==========================================================
// identity (values arbitrary) and fixed bytes
`define MAKER_CODE 8'h5A
`define SERIAL_NUMBER 48'h0123_4567_89AB
`define PAGE1_BYTE3 8'h00
`define ATQA_BYTES 16'h0000
`define HOST_PROT_WR 2'b01
`define ZERO8 8'h00
`define ZERO16 16'h0000
`define ZERO32 32'h0000_0000
`define FAIL_ONE 8'h01
`define FAIL_MAX 8'hFF
`endif

// file: tag_access_props.sv
// assertion checker for the tag memory access control block
`timescale 1ns/1ps
module tag_access_props (
  input wire clk,
  input wire srst,
  input wire [7:0] radio_page,
  input wire radio_wr,
  input wire radio_rd,
  input wire [31:0] radio_rdata,
  input wire radio_ack,
  input wire radio_nak,
  input wire [7:0] host_page,
  input wire host_wr,
  input wire host_nak,
  input wire cmd_valid,
  input wire [7:0] cmd_code,
  input wire cascade_one_select,
  input wire cascade_two_select,
  input wire [31:0] cascade_data,
  input wire password_check,
  input wire auth_ok,
  input wire auth_fail,
  input wire authenticated,
  input wire field_present,
  input wire field_flag_pin_oe
);
  // ==========================================================
  // timing and access relations, one clock domain
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  AST_ONE_ANSWER: assert property ((radio_wr || radio_rd) |=> radio_ack != radio_nak)
    else $error("radio access answered wrongly");
  AST_SERIAL_FIXED: assert property (radio_wr && radio_page <= 8'h01 |=> radio_nak)
    else $error("radio write to serial page taken");
  AST_HOST_SERIAL: assert property (host_wr && host_page <= 8'h01 |=> host_nak)
    else $error("host write to serial page taken");
  AST_PWD_ZERO: assert property (radio_rd && radio_page inside {8'hE5, 8'hE6} |=> radio_rdata == 32'h0000_0000)
    else $error("password page read not zero");
  AST_LEVEL_ONE: assert property (cmd_valid && cmd_code == 8'h93 |=> cascade_one_select && cascade_data[31:24] == 8'h88)
    else $error("level one select missing");
  AST_LEVEL_TWO: assert property (cmd_valid && cmd_code == 8'h95 |=> cascade_two_select && !cascade_one_select)
    else $error("level two select missing");
  AST_NO_SELECT: assert property (!cmd_valid |=> !cascade_one_select && !cascade_two_select)
    else $error("select without command");
  AST_CHECK_ANSWER: assert property (password_check |=> auth_ok != auth_fail)
    else $error("password check unanswered");
  AST_FIELD_LOSS: assert property (!field_present |=> !authenticated && !field_flag_pin_oe)
    else $error("field loss not honoured");
  cover property (radio_nak);
  cover property (auth_ok && authenticated);
  cover property (cascade_two_select);
endmodule
bind tag_memory_access_control tag_access_props u_props (.*);

// file: reader_model.sv
// contactless reader model driving the radio page port
`timescale 1ns/1ps
module reader_model (
  input wire clk,
  output reg [7:0] radio_page = 8'h00,
  output reg [31:0] radio_wdata = 32'h0000_0000,
  output reg radio_wr = 1'b0,
  output reg radio_rd = 1'b0
);
  // access byte, held at zero; zero nibbles grant reads and writes
  reg [7:0] cap_access = 8'h00;
  // one page per request; idle lines show the inverse, never stale data
  task req(input logic w, input logic [7:0] p, input logic [31:0] d);
    @(posedge clk);
    radio_page <= p;
    radio_wdata <= d;
    radio_wr <= w && cap_access[3:0] != 4'hF;
    radio_rd <= !w && cap_access[7:4] == 4'h0;
    @(posedge clk);
    radio_wr <= 1'b0;
    radio_rd <= 1'b0;
    radio_page <= ~p;
    radio_wdata <= ~d;
  endtask
endmodule

// file: tb_tag_memory_access_control.sv
// self-checking bench for the tag memory access control block
`timescale 1ns/1ps
module tb_tag_memory_access_control;
  logic clk, srst, host_wr, host_rd, cmd_valid, password_check, selected;
  logic field_present, sof_seen, halted, buf_ready_for_host;
  logic buf_read_by_reader, buf_last_read_by_host;
  logic [7:0] host_page, cmd_code;
  logic [31:0] host_wdata, password_try, rnd;
  wire [7:0] radio_page, final_message_block, mirror_base_block;
  wire [31:0] radio_wdata, radio_rdata, host_rdata, cascade_data;
  wire radio_wr, radio_rd, radio_ack, radio_nak, host_ack, host_nak;
  wire cascade_one_select, cascade_two_select, auth_ok, auth_fail;
  wire authenticated, auth_locked_out, field_flag_pin_o, field_flag_pin_oe;
  wire silence_and_soft_reset_enable, passthru_enable, mirror_enable;
  wire transfer_dir, passthru_password_protect;
  wire [1:0] host_port_protect;
  wire [15:0] password_ack_value, watchdog_timeout;
  logic [33:0] qr[$], qh[$], x;
  int num_errors = 0, n_compared = 0, cyc = 0;
  tag_memory_access_control DUT (.*);
  reader_model rm (.*);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ==========================================================
  // compare, access and closing tasks
  task chk(input logic [33:0] g, input logic [33:0] e);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("FAIL %0t got %h exp %h", $time, g, e);
    end
  endtask
  // note {read, refused, data} first, then issue the access
  task acc(input logic h, input logic w, input logic [7:0] p,
           input logic [31:0] d, input logic n, input logic [31:0] e);
    if (h) begin
      qh.push_back({!w, n, w ? 32'h0000_0000 : e});
      @(posedge clk);
      {host_page, host_wdata, host_wr, host_rd} <= {p, d, w, !w};
      @(posedge clk);
      {host_page, host_wr, host_rd} <= {~p, 2'b00};
    end else begin
      qr.push_back({!w, n, w ? 32'h0000_0000 : e});
      rm.req(w, p, d);
    end
  endtask
  task password_value(input logic [31:0] t, input logic [1:0] e);
    @(posedge clk);
    {password_check, password_try} <= {1'b1, t};
    @(posedge clk);
    password_check <= 1'b0;
    @(negedge clk);
    chk({auth_ok, auth_fail, authenticated}, {e, e[1]});
  endtask
  task stop_test();
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ==========================================================
  // answer monitor pops the oldest note; a hang is cut short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc > 3000) begin
      num_errors++;
      stop_test();
    end
    if (radio_ack !== radio_nak) begin
      x = qr.pop_front();
      chk({x[33], radio_nak, x[33] ? radio_rdata : 32'h0}, x);
    end
    if (host_ack !== host_nak) begin
      x = qh.pop_front();
      chk({x[33], host_nak, x[33] ? host_rdata : 32'h0}, x);
    end
  end
  // ==========================================================
  // main sequence
  initial begin
    {srst, host_wr, host_rd, cmd_valid, password_check, selected} = 6'h20;
    {sof_seen, halted, buf_ready_for_host, buf_read_by_reader} = 4'h0;
    {buf_last_read_by_host, field_present} = 2'b01;
    {host_page, cmd_code, host_wdata, password_try} = 80'h0;
    void'($urandom(51350));
    rnd = $urandom;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    acc(1, 0, 8'h03, 0, 0, 32'hE110_6D00);
    acc(1, 0, 8'h04, 0, 0, 32'h0300_FE00);
    acc(0, 0, 8'hE3, 0, 0, 32'h0000_00FF);
    acc(0, 0, 8'hE5, 0, 0, 0);
    acc(0, 1, 8'h00, rnd, 1, 0);
    acc(1, 1, 8'h01, rnd, 1, 0);
    acc(0, 0, 8'hF0, 0, 1, 0);
    chk(watchdog_timeout, 16'h0848);
    $display("test reset done");
    acc(0, 1, 8'h03, 1, 0, 0);
    acc(0, 0, 8'h03, 0, 0, 32'hE110_6D01);
    acc(0, 1, 8'h05, rnd, 0, 0);
    acc(0, 1, 8'h02, 32'h0000_2000, 0, 0);
    acc(0, 1, 8'h05, ~rnd, 1, 0);
    acc(0, 0, 8'h05, 0, 0, rnd);
    acc(1, 1, 8'h02, 0, 0, 0);
    acc(0, 1, 8'h05, ~rnd, 0, 0);
    $display("test locks done");
    acc(1, 1, 8'hE3, 32'h0000_0010, 0, 0);
    acc(0, 1, 8'h10, rnd, 1, 0);
    password_value(32'h0, 2'b01);
    password_value(32'hFFFF_FFFF, 2'b10);
    acc(0, 1, 8'h10, rnd, 0, 0);
    $display("test auth done");
    acc(1, 1, 8'hE8, 32'h4201_0348, 0, 0);
    @(negedge clk);
    chk({passthru_enable, mirror_enable, transfer_dir, final_message_block,
         mirror_base_block}, {19'h0, 3'b110, 16'h0103});
    acc(0, 1, 8'hE9, 32'h0900_0100, 0, 0);
    @(negedge clk);
    chk(watchdog_timeout, 16'h0948);
    acc(0, 1, 8'hE8, 0, 1, 0);
    $display("test config done");
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      {cmd_valid, selected, cmd_code} <= {2'b11, i ? 8'h95 : 8'h93};
      @(posedge clk);
      {cmd_valid, selected} <= 2'b00;
      @(negedge clk);
      chk({cascade_one_select, cascade_two_select, cascade_data},
          {i ? 2'b01 : 2'b10, i ? 32'h6789_AB5A : 32'h8801_2345});
    end
    chk(field_flag_pin_oe, 1'b1);
    field_present <= 1'b0;
    repeat (2) @(negedge clk);
    chk({field_flag_pin_oe, authenticated}, 2'b00);
    $display("test field done");
    acc(1, 1, 8'hE4, 32'h0100_0000, 0, 0);
    repeat (3) password_value(32'h1, 2'b01);
    password_value(32'hFFFF_FFFF, 2'b01);
    chk(auth_locked_out, 1'b1);
    acc(1, 1, 8'hE7, 32'h0100_0000, 0, 0);
    acc(1, 1, 8'h10, 0, 1, 0);
    $display("test limits done");
    stop_test();
  end
endmodule
